// ==== pic_pkg.sv ====
// package for the host-side driver of an eight-input priority interrupt controller
// assumes a 40 MHz i_clk; all pin timings are counted in cycles of it
package pic_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS   = 25;
  localparam int STROBE_MIN_NS   = 250;
  localparam int RECOVER_MIN_NS  = 200;
  localparam int STROBE_CYC      = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC     = (RECOVER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT  = 4'(STROBE_CYC);
  localparam logic [3:0] RECOVER_CNT = 4'(RECOVER_CYC);
  // ***************************************************************
  // word select, acknowledge sequence, command word fields
  // ***************************************************************
  localparam logic       WSEL_EVEN      = 1'h0;
  localparam logic       WSEL_ODD       = 1'h1;
  localparam logic [1:0] ACK_PULSES_SHORT = 2'h2;
  localparam logic [1:0] ACK_PULSES_LONG  = 2'h3;
  localparam int         INIT_LEVEL_BIT = 3;
  localparam int         INIT_START_BIT = 4;
  localparam logic [7:0] IDLE_DATA      = 8'h00;
  localparam logic [2:0] IDLE_CAS       = 3'h0;

  typedef enum logic [2:0]
  {
    PIC_IDLE    = 3'b000,
    PIC_SETUP   = 3'b001,
    PIC_STROBE  = 3'b010,
    PIC_RECOVER = 3'b011,
    PIC_DONE    = 3'b100
  } pic_state_e;
endpackage : pic_pkg

// ==== pic_strobe_if.sv ====
// strobe timer handshake between the sequencer and its pulse timer
// assumes one clock domain
interface pic_strobe_if;
  logic       start;   // load timer
  logic [3:0] count;   // cycles to run
  logic       busy;    // timer running
  modport seq (output start, output count, input busy);
  modport tmr (input start, input count, output busy);
endinterface : pic_strobe_if

// ==== pic_strobe_timer.sv ====
// cycle timer that stretches strobes and recovery gaps on the device pins
// assumes the reset given is already synchronised
module pic_strobe_timer
(
  input  wire logic   i_clk,     // system clock
  input  wire logic   i_rst_n,   // synchronised reset
  pic_strobe_if.tmr   tif        // timer port
);
  typedef struct packed
  {
    logic [3:0] cnt_reg;
  } pic_tmr_s;
  pic_tmr_s st_reg;
  pic_tmr_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (tif.start)
      st_next.cnt_reg = tif.count;
    else if (st_reg.cnt_reg != 4'h0)
      st_next.cnt_reg = st_reg.cnt_reg - 4'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // busy must not look at start: the sequencer raises start from !busy, a loop otherwise
  assign tif.busy = (st_reg.cnt_reg > 4'h1);

  // ***************************************************************
  // checks
  // ***************************************************************
  timer_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tif.start && tif.count > 4'h2 |=> tif.busy)
    else $error("timer did not hold busy after load");
endmodule : pic_strobe_timer

// ==== pic_host.sv ====
// host-side driver for an eight-input priority interrupt controller
// assumes the device pins are synchronous to i_clk; the device model resolves the data bus
module pic_host
(
  input  wire logic       i_clk,          // 40 MHz clock
  input  wire logic       i_resetn,       // async reset, active low
  input  wire logic       i_cmd_valid,    // user request valid
  output logic            o_cmd_ready,    // request accepted this cycle
  input  wire logic [1:0] i_cmd_kind,     // 0 write, 1 read, 2 acknowledge
  input  wire logic       i_cmd_wsel,     // word select for reads/writes
  input  wire logic [7:0] i_cmd_data,     // byte to write
  input  wire logic       i_cmd_long_ack, // three-pulse acknowledge
  output logic            o_rsp_valid,    // answer pulse
  output logic [7:0]      o_rsp_data,     // status or last vector byte
  output logic [15:0]     o_rsp_vector,   // earlier vector bytes
  output logic            o_irq,          // device interrupt seen
  output logic [2:0]      o_cascade_id,   // cascade code at acknowledge
  input  wire logic       i_irq,          // device interrupt output
  output logic            o_chip_sel_n,   // chip select, low active
  output logic            o_rd_n,         // read strobe
  output logic            o_wr_n,         // write strobe
  output logic            o_irq_ack_n,    // acknowledge strobe
  output logic            o_word_select,  // word select pin
  input  wire logic [7:0] i_host_data_bus,// data bus in
  output logic [7:0]      o_host_data_bus,// data bus out
  output logic            o_host_data_oe, // data bus drive enable
  input  wire logic [2:0] i_cascade_id_bus // cascade lines from a master
);
  localparam logic [1:0] KIND_WR  = 2'h0;
  localparam logic [1:0] KIND_RD  = 2'h1;
  localparam logic [1:0] KIND_ACK = 2'h2;

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic [1:0] rst_sync_reg;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
  end
  wire logic rst_n = rst_sync_reg[1];

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed
  {
    pic_pkg::pic_state_e fsm;
    logic [1:0]          kind;
    logic                wsel;
    logic [7:0]          wdata;
    logic [1:0]          pulses;
    logic [1:0]          pulse_idx;
    logic                cs_n;
    logic                rd_n;
    logic                wr_n;
    logic                ack_n;
    logic                oe;
    logic [23:0]         bytes;
    logic [2:0]          cas;
    logic                irq_sync;
    logic                rsp;
  } pic_host_s;
  pic_host_s st_reg;
  pic_host_s st_next;

  pic_strobe_if tif ();
  pic_strobe_timer u_timer
  (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .tif     (tif)
  );

  wire logic accept = (st_reg.fsm == pic_pkg::PIC_IDLE) && i_cmd_valid
                      && (i_cmd_kind != 2'h3);

  always_comb
  begin
    st_next     = st_reg;
    st_next.rsp = 1'h0;
    st_next.irq_sync = i_irq;
    tif.start   = 1'h0;
    tif.count   = pic_pkg::STROBE_CNT;
    unique case (st_reg.fsm)
      pic_pkg::PIC_IDLE:
      begin
        if (accept)
        begin
          st_next.kind      = i_cmd_kind;
          st_next.wsel      = i_cmd_wsel;
          st_next.wdata     = i_cmd_data;
          st_next.pulses    = i_cmd_long_ack ? pic_pkg::ACK_PULSES_LONG
                                             : pic_pkg::ACK_PULSES_SHORT;
          st_next.pulse_idx = 2'h0;
          st_next.bytes     = 24'h000000;
          // acknowledge never touches chip select
          st_next.cs_n      = (i_cmd_kind == KIND_ACK);
          st_next.oe        = (i_cmd_kind == KIND_WR);
          st_next.fsm       = pic_pkg::PIC_SETUP;
        end
      end
      pic_pkg::PIC_SETUP:
      begin
        tif.start   = 1'h1;
        tif.count   = pic_pkg::STROBE_CNT;
        st_next.wr_n  = !(st_reg.kind == KIND_WR);
        st_next.rd_n  = !(st_reg.kind == KIND_RD);
        st_next.ack_n = !(st_reg.kind == KIND_ACK);
        st_next.fsm   = pic_pkg::PIC_STROBE;
      end
      pic_pkg::PIC_STROBE:
      begin
        if (!tif.busy)
        begin
          // sample at strobe end: data has settled for the whole low time
          if (st_reg.kind != KIND_WR)
            st_next.bytes = {st_reg.bytes[15:0], i_host_data_bus};
          if (st_reg.kind == KIND_ACK && st_reg.pulse_idx == 2'h0)
            st_next.cas = i_cascade_id_bus;
          st_next.wr_n  = 1'h1;
          st_next.rd_n  = 1'h1;
          st_next.ack_n = 1'h1;
          st_next.pulse_idx = st_reg.pulse_idx + 2'h1;
          tif.start     = 1'h1;
          tif.count     = pic_pkg::RECOVER_CNT;
          st_next.fsm   = pic_pkg::PIC_RECOVER;
        end
      end
      pic_pkg::PIC_RECOVER:
      begin
        st_next.oe = 1'h0;
        if (!tif.busy)
        begin
          if (st_reg.kind == KIND_ACK && st_reg.pulse_idx != st_reg.pulses)
            st_next.fsm = pic_pkg::PIC_SETUP;
          else
          begin
            st_next.cs_n = 1'h1;
            st_next.fsm  = pic_pkg::PIC_DONE;
          end
        end
      end
      pic_pkg::PIC_DONE:
      begin
        st_next.rsp = 1'h1;
        st_next.fsm = pic_pkg::PIC_IDLE;
      end
      default:
        st_next.fsm = pic_pkg::PIC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= '0;
      st_reg.fsm   <= pic_pkg::PIC_IDLE;
      st_reg.cs_n  <= 1'h1;
      st_reg.rd_n  <= 1'h1;
      st_reg.wr_n  <= 1'h1;
      st_reg.ack_n <= 1'h1;
      st_reg.cas   <= pic_pkg::IDLE_CAS;
    end
    else
      st_reg <= st_next;
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_cmd_ready     = accept;
  assign o_rsp_valid     = st_reg.rsp;
  assign o_rsp_data      = st_reg.bytes[7:0];
  assign o_rsp_vector    = st_reg.bytes[23:8];
  assign o_irq           = st_reg.irq_sync;
  assign o_cascade_id    = st_reg.cas;
  assign o_chip_sel_n    = st_reg.cs_n;
  assign o_rd_n          = st_reg.rd_n;
  assign o_wr_n          = st_reg.wr_n;
  assign o_irq_ack_n     = st_reg.ack_n;
  assign o_word_select   = st_reg.wsel;
  assign o_host_data_bus = st_reg.oe ? st_reg.wdata : pic_pkg::IDLE_DATA;
  assign o_host_data_oe  = st_reg.oe;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence ack_pulse_s;
    !o_irq_ack_n [*2];
  endsequence
  sequence strobe_low_s;
    (!o_rd_n || !o_wr_n);
  endsequence

  select_on_access_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    strobe_low_s |-> !o_chip_sel_n)
    else $error("register strobe without chip select");
  ack_unselected_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_irq_ack_n |-> o_chip_sel_n)
    else $error("acknowledge drove chip select");
  write_drives_bus_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_wr_n |-> o_host_data_oe && o_host_data_bus == st_reg.wdata)
    else $error("write strobe without data driven");
  read_bus_free_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_rd_n || !o_irq_ack_n |-> !o_host_data_oe)
    else $error("host drove bus during read or acknowledge");
  strobe_width_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    $fell(o_irq_ack_n) |-> ack_pulse_s)
    else $error("acknowledge pulse too short");
  strobes_exclusive_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    $onehot0({!o_rd_n, !o_wr_n, !o_irq_ack_n}))
    else $error("two strobes low together");
  answer_bound_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    accept && i_cmd_kind != KIND_ACK |-> ##[20:30] o_rsp_valid)
    else $error("access answer out of window");
  irq_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_irq |=> o_irq)
    else $error("interrupt not reflected");
endmodule : pic_host

// ==== pic_dev_model.sv ====
// behavioural model of the eight-input interrupt controller, edge or level mode, master strap
// assumes pins synchronous to i_clk; it also resolves the shared data bus
module pic_dev_model
(
  input  wire logic       i_clk,      // clock
  input  wire logic       i_resetn,   // model reset, active low
  input  wire logic       i_cs_n,     // chip select
  input  wire logic       i_rd_n,     // read strobe
  input  wire logic       i_wr_n,     // write strobe
  input  wire logic       i_ack_n,    // irq_ack_n
  input  wire logic       i_wsel,     // word_select
  input  wire logic [7:0] i_host_out, // host drive value
  input  wire logic       i_host_oe,  // host drive enable
  input  wire logic [7:0] i_req,      // request_in
  output logic [7:0]      o_bus,      // resolved host_data_bus
  output logic [2:0]      o_cas,      // cascade_id_bus
  output logic            o_irq       // interrupt out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] word_reg [2];
  logic [7:0] pend_reg, isr_reg, req_reg, flt_reg, dout, pend_next;
  logic [1:0] cnt_reg;
  logic [4:0] idle_reg;
  logic [2:0] lvl_reg, top;
  logic       ack_reg, drv, any, lvl_mode_reg;

  always_comb
  begin
    top = 3'h7;
    any = 1'b0;
    for (int i = 7; i >= 0; i--)
      if (pend_reg[i] && !word_reg[1][i])
      begin
        top = 3'(i);
        any = 1'b1;
      end
    pend_next = pend_reg | (i_req & (lvl_mode_reg ? 8'hFF : ~req_reg));
    if (ack_reg && !i_ack_n && cnt_reg == 2'h0 && any)
      pend_next = pend_next & ~(8'h01 << top);
    o_irq = any && !(|(isr_reg & ~(8'hFE << top)));
    case (cnt_reg)
      2'h1:    dout = 8'hCD;
      2'h2:    dout = {word_reg[0][7:5], lvl_reg, 2'h0};
      default: dout = word_reg[0];
    endcase
    if (!i_cs_n && !i_rd_n)
      dout = i_wsel ? word_reg[1] : pend_reg;
    drv   = (!i_cs_n && !i_rd_n) || (!i_ack_n && cnt_reg != 2'h0);
    o_bus = i_host_oe ? i_host_out : (drv ? dout : flt_reg);
    // unbuffered master: the dual pin is a strap tied high, never a transceiver enable
    o_cas = (cnt_reg != 2'h0) ? lvl_reg : flt_reg[2:0];
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      word_reg <= '{8'h00, 8'h00};
      {pend_reg, isr_reg, req_reg, flt_reg} <= 32'h0;
      {cnt_reg, idle_reg, lvl_reg} <= 10'h0;
      ack_reg <= 1'b1;
      lvl_mode_reg <= 1'b0;
    end
    else
    begin
      req_reg   <= i_req;
      flt_reg   <= ~o_bus;
      ack_reg   <= i_ack_n;
      if (!i_cs_n && !i_wr_n)
      begin
        word_reg[i_wsel] <= o_bus;
        if (!i_wsel)
          isr_reg <= 8'h00; // even write ends service
        if (!i_wsel && o_bus[pic_pkg::INIT_START_BIT])
          lvl_mode_reg <= o_bus[pic_pkg::INIT_LEVEL_BIT];
      end
      if (ack_reg && !i_ack_n)
      begin
        cnt_reg <= cnt_reg + 2'h1;
        if (cnt_reg == 2'h0)
        begin
          lvl_reg <= top;
          if (any)
            isr_reg   <= isr_reg | (8'h01 << top);
        end
      end
      pend_reg <= pend_next;
      idle_reg <= i_ack_n ? (idle_reg == 5'h1F ? idle_reg : idle_reg + 5'h1) : 5'h0;
      if (idle_reg == 5'h14)
        cnt_reg <= 2'h0; // long gap ends the sequence
    end
  end
endmodule : pic_dev_model

// ==== pic_host_bench.sv ====
// self-checking bench of the host-side driver against the device model
// assumes pic_pkg, pic_strobe_if, pic_strobe_timer, pic_host, pic_dev_model compiled first
module pic_host_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk, i_resetn, cmd_valid, wsel, long_ack, ready, rsp_valid, irq_o, dev_irq;
  logic        cs_n, rd_n, wr_n, ack_n, wsel_pin, hoe;
  logic [1:0]  kind;
  logic [7:0]  cdata, req, rsp_data, bus, hout;
  logic [2:0]  cas_o, cas;
  logic [15:0] rsp_vec, lf;
  int          n_fail, compares, cyc, pend, in_service_bits, lvl, words [2];

  pic_host pic_host_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(ready), .i_cmd_kind(kind), .i_cmd_wsel(wsel), .i_cmd_data(cdata),
    .i_cmd_long_ack(long_ack), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_vector(rsp_vec), .o_irq(irq_o), .o_cascade_id(cas_o), .i_irq(dev_irq),
    .o_chip_sel_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_irq_ack_n(ack_n),
    .o_word_select(wsel_pin), .i_host_data_bus(bus), .o_host_data_bus(hout),
    .o_host_data_oe(hoe), .i_cascade_id_bus(cas));
  pic_dev_model pic_dev_model_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ack_n(ack_n), .i_wsel(wsel_pin), .i_host_out(hout),
    .i_host_oe(hoe), .i_req(req), .o_bus(bus), .o_cas(cas), .o_irq(dev_irq));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function int pick();
    for (int i = 0; i < 8; i++)
      if (pend[i] && !words[1][i])
        return i;
    return 8;
  endfunction : pick

  function logic exp_irq();
    int p;
    p = pick();
    return p < 8 && (in_service_bits & ((1 << (p + 1)) - 1)) == 0;
  endfunction : exp_irq

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test();
    $display("mismatches %0d, comparisons %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task cmd(input logic [1:0] k, input logic w, input logic [7:0] d, input logic l);
    int t;
    @(posedge i_clk);
    {cmd_valid, kind, wsel, cdata, long_ack} <= {1'b1, k, w, d, l};
    t = 0;
    do
    begin
      @(negedge i_clk);
      t++;
    end
    while (ready !== 1'b1 && t < 100);
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    t = 0;
    while (rsp_valid !== 1'b1 && t < 200)
    begin
      @(negedge i_clk);
      t++;
    end
    if (t >= 200)
      n_fail++;
    if (k == 2'h0)
      words[w] = d;
    if (k == 2'h0 && !w)
      in_service_bits = 0;
    if (k == 2'h0 && !w && d[pic_pkg::INIT_START_BIT])
      lvl = d[pic_pkg::INIT_LEVEL_BIT];
  endtask : cmd

  task ack(input logic l);
    int p;
    logic [7:0] b2;
    p = pick();
    b2 = {3'(words[0] >> 5), 3'(p < 8 ? p : 7), 2'h0};
    if (p < 8)
    begin
      pend &= ~(1 << p);
      in_service_bits |= 1 << p;
    end
    cmd(2'h2, 1'b0, 8'h00, l);
    chk(cas_o, 16'(p < 8 ? p : 7));
    if (l)
      chk({rsp_vec, rsp_data} >> 8, {8'hCD, b2});
    chk(l ? rsp_data : {rsp_vec[7:0], rsp_data}, l ? 16'(words[0]) : {8'hCD, b2});
  endtask : ack

  always @(negedge i_clk)
    if (i_resetn)
    begin
      if (!ack_n)
        chk({cs_n, hoe}, 2'h2);
      if (!rd_n || !wr_n)
        chk({cs_n, hoe}, {1'b0, !wr_n});
    end

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    {cmd_valid, kind, wsel, cdata, long_ack, req, i_resetn} = 22'h0;
    {n_fail, compares, cyc, pend, in_service_bits, lvl} = 192'h0;
    words = '{0, 0};
    lf = 16'hC6CD;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({cs_n, rd_n, wr_n, ack_n, hoe}, 5'h1E);
    @(posedge i_clk);
    {cmd_valid, kind} <= 3'h7;
    repeat (4)
    begin
      @(negedge i_clk);
      chk(ready, 1'b0);
    end
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    ack(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      cmd(2'h0, 1'b1, lf[7:0] & lf[15:8], 1'b0);
      lf = lfsr(lf);
      cmd(2'h0, 1'b0, lf[7:0], 1'b0);
      lf = lfsr(lf);
      @(posedge i_clk);
      req <= lf[7:0];
      pend |= lf[7:0];
      repeat (4) @(negedge i_clk);
      chk(irq_o, exp_irq());
      cmd(2'h1, 1'b0, 8'h00, 1'b0);
      chk(rsp_data, 16'(pend));
      cmd(2'h1, 1'b1, 8'h00, 1'b0);
      chk(rsp_data, 16'(words[1]));
      ack(i[0]);
      // a level request still high re-pends at once after the acknowledge
      if (lvl)
        pend |= req;
      repeat (4) @(negedge i_clk);
      chk(irq_o, exp_irq());
      @(posedge i_clk);
      req <= 8'h00;
    end
    stop_test();
  end
endmodule : pic_host_bench
